/* scsi_info_pkg.sv */
/*
 * constants for the target-side information transfer phases:
 * bus phase codes, status codes, message codes, register map.
 * assumes a single 250 MHz clock domain.
 */
package scsi_info_pkg;
	// avalon register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_INFO = 8'h0C;
	// ctrl fields
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_ABORT_BIT = 1;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
	// status byte layout
	localparam int STAT_CODE_LSB = 1;
	localparam logic [3:0] ST_GOOD = 4'h0;
	localparam logic [3:0] ST_CHECK = 4'h1;
	localparam logic [3:0] ST_BUSY = 4'h4;
	localparam logic [3:0] ST_INTERMEDIATE = 4'h8;
	localparam logic [3:0] ST_RES_CONFLICT = 4'hC;
	// message codes
	localparam logic [7:0] MSG_CMD_COMPLETE = 8'h00;
	localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
	localparam logic [7:0] MSG_DISCONNECT = 8'h04;
	localparam logic [7:0] MSG_INIT_ERROR = 8'h05;
	localparam logic [7:0] MSG_ABORT = 8'h06;
	localparam logic [7:0] MSG_REJECT = 8'h07;
	localparam logic [7:0] MSG_NOP = 8'h08;
	localparam logic [7:0] MSG_PARITY_ERR = 8'h09;
	localparam logic [7:0] MSG_LINKED = 8'h0A;
	localparam logic [7:0] MSG_LINKED_FLAG = 8'h0B;
	localparam logic [7:0] MSG_DEV_RESET = 8'h0C;
	localparam int IDENT_BIT = 7;
	localparam int IDENT_DISC_BIT = 6;
	// job kinds written to ctrl bits 3:2
	localparam logic [1:0] JOB_NONE = 2'h0;
	localparam logic [1:0] JOB_IN = 2'h1;
	localparam logic [1:0] JOB_OUT = 2'h2;
	// bus settle / hold time after req rises, before ack is taken
	localparam int SETTLE_NS = 100;
	localparam int CLK_NS = 4;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// phase states
	typedef enum logic [7:0] {
		PH_IDLE = 8'b0000_0001,
		PH_DATA = 8'b0000_0010,
		PH_STATUS = 8'b0000_0100,
		PH_MSGIN = 8'b0000_1000,
		PH_MSGOUT = 8'b0001_0000,
		PH_REJECT = 8'b0010_0000,
		PH_FREE = 8'b0100_0000,
		PH_DONE = 8'b1000_0000
	} phase_t;
endpackage

/* scsi_target_info.sv */
/*
 * target-side scsi information transfer: data in/out, status byte,
 * single-byte messages, all over async req/ack.
 * assumes arbitration/selection done outside (i_connected), scsi pins
 * are decoded true-high by pad logic, avalon master on i_clk.
 */
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
// Summary of operation
// RULE_01 - direction from command; none skips data
// RULE_02 - asynchronous req/ack only, no offset
// RULE_03 - bus reset or power fail releases busy
// RULE_04 - check parity on every data-out byte
// RULE_05 - atn with ack: enter message out; the data-out phase (job JOB_OUT) ignores atn and stays in data
// RULE_06 - status byte: zeros, code, unit flag
// RULE_07 - unit flag set for unconfigured unit
// RULE_08 - status code encodings per table
// RULE_09 - busy target may return busy immediately
// RULE_10 - foreign reservation gives reservation conflict
// RULE_11 - linked commands return intermediate status
// RULE_12 - initiator waits 200 us after busy
// RULE_13 - every sent message is one byte
// RULE_14 - command complete after status, release busy
// RULE_15 - save pointer, disconnect, then release busy
// RULE_16 - abort clears unit, goes bus free
// RULE_17 - undefined message answered with reject
// RULE_18 - idle initiator sends no operation
// RULE_19 - message parity error: resend once
// RULE_20 - linked complete 0A, 0B with flag
// RULE_21 - device reset acts as hard reset
// RULE_22 - identify 80-FF: disconnect bit, unit
// RULE_23 - hard reset drops commands and reservations
// RULE_24 - data-out parity error gives check condition
`timescale 1ns/10ps
module scsi_target_info
	import scsi_info_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// avalon-mm slave
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// scsi pins, true-high
	input wire logic i_rst,
	input wire logic i_ack,
	input wire logic i_atn,
	input wire logic [7:0] i_db,
	input wire logic i_dbp,
	output logic [7:0] o_db,
	output logic o_dbp,
	output logic o_db_oe,
	output logic o_req,
	output logic o_bsy,
	output logic o_cd,
	output logic o_io,
	output logic o_msg,
	// system
	input wire logic i_power_fail,
	input wire logic i_connected,
	output logic o_lun_cleared
);

	function automatic logic odd_par(input logic [7:0] b);
		odd_par = ~(^b);
	endfunction

	// pin synchronisers
	logic [11:0] sy1_reg;
	logic [11:0] sy2_reg;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sy1_reg <= 12'h000;
			sy2_reg <= 12'h000;
		end else begin
			sy1_reg <= {i_rst, i_ack, i_atn, i_dbp, i_db};
			sy2_reg <= sy1_reg;
		end
	end
	logic s_rst, s_ack, s_atn, s_dbp;
	logic [7:0] s_db;
	assign {s_rst, s_ack, s_atn, s_dbp, s_db} = sy2_reg;

	// software registers
	logic [31:0] ctrl_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic rdata_full_reg;
	logic wdata_full_reg;
	logic par_err_reg;
	logic [7:0] last_msg_reg;
	logic [7:0] ident_reg;
	logic retried_reg;
	logic reserved_reg;
	logic [3:0] code_reg;
	logic wait_reg;
	phase_t phase_reg;
	logic [5:0] settle_reg;
	logic hs_reg;
	logic [1:0] msg_step_reg;

	// ctrl: 0 go, 1 abort, 3:2 job, 4 unconfigured unit, 5 busy,
	// 6 foreign reservation, 7 link, 8 flag, 9 disconnect, 10 reserve
	wire [1:0] job = ctrl_reg[3:2];
	wire unconf = ctrl_reg[4];
	wire busy_lun = ctrl_reg[5];
	wire foreign = ctrl_reg[6];
	wire link = ctrl_reg[7];
	wire flag = ctrl_reg[8];
	wire disc = ctrl_reg[9];
	wire hard_rst = s_rst | i_power_fail; // [RULE_03]
	wire dev_rst_msg;
	wire abort_msg;

	wire data_acc = (phase_reg == PH_DATA);
	// data register waits while the byte cannot move yet
	wire stall_w = i_write && i_address == OFS_DATA && wdata_full_reg;
	wire stall_r = i_read && i_address == OFS_DATA && !rdata_full_reg;

	// avalon slave: one-cycle wait, longer for stalled data access
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h0000_0000;
		end else if (!o_waitrequest) begin
			o_waitrequest <= 1'b1;
		end else if ((i_read | i_write) && !stall_w && !stall_r) begin
			o_waitrequest <= 1'b0;
			if (i_address == OFS_CTRL) begin
				o_readdata <= ctrl_reg;
			end else if (i_address == OFS_STATUS) begin
				o_readdata <= {16'h0000, phase_reg, 1'b0, reserved_reg,
					retried_reg, par_err_reg, rdata_full_reg,
					wdata_full_reg, hs_reg, i_connected};
			end else if (i_address == OFS_DATA) begin
				o_readdata <= {24'h000000, rdata_reg};
			end else if (i_address == OFS_INFO) begin
				o_readdata <= {16'h0000, last_msg_reg, ident_reg};
			end else begin
				o_readdata <= 32'h0000_0000;
			end
		end
	end
	wire wr_ok = i_write & ~o_waitrequest;
	wire rd_ok = i_read & ~o_waitrequest;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= CTRL_RESET_VAL;
		end else if (hard_rst || dev_rst_msg) begin
			ctrl_reg <= CTRL_RESET_VAL; // [RULE_21] [RULE_23]
		end else if (wr_ok && i_address == OFS_CTRL) begin
			ctrl_reg <= i_writedata;
		end else if (phase_reg != PH_IDLE) begin // abort waits for data end
			ctrl_reg[CTRL_GO_BIT] <= 1'b0;
			ctrl_reg[CTRL_ABORT_BIT] <= data_acc & ctrl_reg[CTRL_ABORT_BIT];
		end
	end

	// reservation held by this initiator, dropped by any reset
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			reserved_reg <= 1'b0;
		end else if (hard_rst || dev_rst_msg || abort_msg) begin
			reserved_reg <= 1'b0; // [RULE_23] [RULE_16]
		end else if (wr_ok && i_address == OFS_CTRL) begin
			reserved_reg <= i_writedata[10];
		end
	end

	// req/ack handshake engine; hs_reg high while req asserted
	wire hs_start;
	wire hs_done = hs_reg && s_ack && settle_reg == 6'd0;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hs_reg <= 1'b0;
			wait_reg <= 1'b0;
			settle_reg <= 6'd0;
		end else if (hard_rst || phase_reg == PH_IDLE
				|| phase_reg == PH_FREE) begin
			hs_reg <= 1'b0;
			wait_reg <= 1'b0;
			settle_reg <= 6'd0;
		end else if (hs_done) begin
			hs_reg <= 1'b0; // [RULE_02]
			wait_reg <= 1'b1;
		end else if (wait_reg) begin
			if (!s_ack) begin
				wait_reg <= 1'b0;
			end
		end else if (settle_reg != 6'd0) begin
			settle_reg <= settle_reg - 6'd1;
		end else if (hs_start) begin
			hs_reg <= 1'b1;
			settle_reg <= 6'(SETTLE_CYC);
		end
	end
	wire hs_idle = !hs_reg && !wait_reg && settle_reg == 6'd0;

	// message decode
	wire ident = s_db[IDENT_BIT];
	wire in_out = phase_reg == PH_MSGOUT && hs_done;
	assign dev_rst_msg = in_out && s_db == MSG_DEV_RESET;
	assign abort_msg = in_out && s_db == MSG_ABORT;
	wire msg_known = ident || s_db == MSG_INIT_ERROR || s_db == MSG_ABORT
		|| s_db == MSG_NOP || s_db == MSG_PARITY_ERR
		|| s_db == MSG_DEV_RESET || s_db == MSG_REJECT;

	// status code choice
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			code_reg <= ST_GOOD;
		end else if (phase_reg == PH_IDLE) begin
			if (busy_lun) begin
				code_reg <= ST_BUSY; // [RULE_09]
			end else if (foreign) begin
				code_reg <= ST_RES_CONFLICT; // [RULE_10]
			end else if (link) begin
				code_reg <= ST_INTERMEDIATE; // [RULE_11]
			end else begin
				code_reg <= ST_GOOD;
			end
		end else if (par_err_reg && code_reg != ST_RES_CONFLICT) begin
			code_reg <= ST_CHECK; // [RULE_24] [RULE_11]
		end
	end
	// [RULE_06] [RULE_07] [RULE_08]
	wire [7:0] status_byte = {3'b000, code_reg, unconf};
	wire [7:0] done_msg = !link ? MSG_CMD_COMPLETE
		: (flag ? MSG_LINKED_FLAG : MSG_LINKED); // [RULE_20] [RULE_14]

	// phase sequencer
	wire go = ctrl_reg[CTRL_GO_BIT] & i_connected;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_reg <= PH_IDLE;
			msg_step_reg <= 2'd0;
		end else if (hard_rst || dev_rst_msg) begin
			phase_reg <= PH_FREE; // [RULE_03] [RULE_21]
		end else begin
			case (phase_reg)
			PH_IDLE: begin
				msg_step_reg <= 2'd0;
				if (go) begin
					if (busy_lun || foreign || job == JOB_NONE) begin
						phase_reg <= PH_STATUS; // [RULE_01] [RULE_09]
					end else begin
						phase_reg <= PH_DATA; // [RULE_01]
					end
				end
			end
			PH_DATA: begin
				if (hs_done && s_atn && job == JOB_IN) begin
					phase_reg <= PH_MSGOUT; // [RULE_05]
				end else if (ctrl_reg[CTRL_ABORT_BIT] && hs_idle && disc
						&& job == JOB_IN) begin
					phase_reg <= PH_MSGIN;
					msg_step_reg <= 2'd2; // [RULE_15]
				end else if (ctrl_reg[CTRL_ABORT_BIT] && hs_idle) begin
					phase_reg <= PH_STATUS;
				end
			end
			PH_STATUS: begin
				if (hs_done) begin
					phase_reg <= s_atn ? PH_MSGOUT : PH_MSGIN;
				end
			end
			PH_MSGIN: begin
				if (hs_done) begin
					if (s_atn) begin
						phase_reg <= PH_MSGOUT;
					end else if (msg_step_reg == 2'd2) begin
						msg_step_reg <= 2'd3; // [RULE_15]
					end else begin
						phase_reg <= PH_FREE; // [RULE_14] [RULE_15]
					end
				end
			end
			PH_MSGOUT: begin
				if (hs_done) begin
					if (abort_msg) begin
						phase_reg <= PH_FREE; // [RULE_16]
					end else if (!msg_known) begin
						phase_reg <= PH_REJECT; // [RULE_17]
					end else if (s_db == MSG_PARITY_ERR && !retried_reg) begin
						phase_reg <= PH_MSGIN; // [RULE_19]
					end else if (!s_atn) begin
						phase_reg <= PH_STATUS;
					end
				end
			end
			PH_REJECT: begin
				if (hs_done) begin
					phase_reg <= s_atn ? PH_MSGOUT : PH_STATUS;
				end
			end
			PH_FREE: begin
				phase_reg <= PH_DONE;
			end
			default: begin
				if (!ctrl_reg[CTRL_GO_BIT]) begin
					phase_reg <= PH_IDLE;
				end
			end
			endcase
		end
	end

	// one retry per message; recorded ident and last message
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			retried_reg <= 1'b0;
			last_msg_reg <= MSG_NOP;
			ident_reg <= 8'h00;
		end else if (phase_reg == PH_IDLE) begin
			retried_reg <= 1'b0;
		end else if (in_out) begin
			last_msg_reg <= s_db;
			if (ident) begin
				ident_reg <= s_db; // [RULE_22]
			end
			if (s_db == MSG_PARITY_ERR) begin
				retried_reg <= 1'b1; // [RULE_19]
			end
		end else if (phase_reg == PH_MSGIN && hs_done) begin
			retried_reg <= 1'b0;
		end
	end

	// data out: receive with parity check; data in: byte from software
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= 8'h00;
			rdata_full_reg <= 1'b0;
			par_err_reg <= 1'b0;
		end else if (phase_reg == PH_IDLE && go) begin
			rdata_full_reg <= 1'b0;
			par_err_reg <= 1'b0;
		end else begin
			if (data_acc && job == JOB_OUT && hs_done) begin
				rdata_reg <= s_db;
				rdata_full_reg <= 1'b1;
				if (s_dbp != odd_par(s_db)) begin
					par_err_reg <= 1'b1; // [RULE_04]
				end
			end else if (rd_ok && i_address == OFS_DATA) begin
				rdata_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wdata_reg <= 8'h00;
			wdata_full_reg <= 1'b0;
		end else if (hard_rst || phase_reg == PH_IDLE) begin
			wdata_full_reg <= 1'b0;
		end else if (wr_ok && i_address == OFS_DATA) begin
			wdata_reg <= i_writedata[7:0];
			wdata_full_reg <= 1'b1;
		end else if (data_acc && job == JOB_IN && hs_done) begin
			wdata_full_reg <= 1'b0;
		end
	end

	// when to request the next byte
	assign hs_start = (data_acc && job == JOB_IN && wdata_full_reg)
		|| (data_acc && job == JOB_OUT && !rdata_full_reg)
		|| phase_reg == PH_STATUS || phase_reg == PH_MSGIN
		|| phase_reg == PH_MSGOUT || phase_reg == PH_REJECT;

	// byte driven in each target-to-initiator phase [RULE_13]
	logic [7:0] tx_byte;
	always_comb begin
		tx_byte = wdata_reg;
		if (phase_reg == PH_STATUS) begin
			tx_byte = status_byte;
		end else if (phase_reg == PH_REJECT) begin
			tx_byte = MSG_REJECT; // [RULE_17]
		end else if (phase_reg == PH_MSGIN) begin
			if (msg_step_reg == 2'd2) begin
				tx_byte = MSG_SAVE_PTR;
			end else if (msg_step_reg == 2'd3) begin
				tx_byte = MSG_DISCONNECT;
			end else begin
				tx_byte = done_msg;
			end
		end
	end
	wire drive = phase_reg == PH_STATUS || phase_reg == PH_MSGIN
		|| phase_reg == PH_REJECT || (data_acc && job == JOB_IN);

	// pin outputs, registered
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_db <= 8'h00;
			o_dbp <= 1'b0;
			o_db_oe <= 1'b0;
			o_req <= 1'b0;
			o_bsy <= 1'b0;
			o_cd <= 1'b0;
			o_io <= 1'b0;
			o_msg <= 1'b0;
			o_lun_cleared <= 1'b0;
		end else begin
			o_db <= tx_byte;
			o_dbp <= odd_par(tx_byte);
			o_db_oe <= drive && !hard_rst;
			o_req <= hs_reg && !hard_rst;
			o_bsy <= !hard_rst && phase_reg != PH_IDLE
				&& phase_reg != PH_FREE && phase_reg != PH_DONE;
			o_cd <= phase_reg == PH_STATUS || phase_reg == PH_MSGIN
				|| phase_reg == PH_MSGOUT || phase_reg == PH_REJECT;
			o_io <= drive;
			o_msg <= phase_reg == PH_MSGIN || phase_reg == PH_MSGOUT
				|| phase_reg == PH_REJECT;
			o_lun_cleared <= abort_msg || dev_rst_msg
				|| (hard_rst && phase_reg != PH_FREE); // one pulse [RULE_23]
		end
	end

endmodule // scsi_target_info

/* scsi_target_info_sva.sv */
/* checker of the scsi_target_info pins and bus answer.
   sees the top ports only; bound to the design at the foot. */
`timescale 1ns/10ps
module scsi_target_info_chk (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_rst,
	input wire logic i_ack,
	input wire logic i_power_fail,
	input wire logic [7:0] o_db,
	input wire logic o_dbp,
	input wire logic o_db_oe,
	input wire logic o_req,
	input wire logic o_bsy,
	input wire logic o_cd,
	input wire logic o_io,
	input wire logic o_msg,
	input wire logic o_waitrequest,
	input wire logic o_lun_cleared
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_req_gap;
		$rose(o_req) |-> !i_ack && !$past(i_ack) && !$past(i_ack, 2);
	endproperty
	a_req_gap: assert property (p_req_gap)
		else $error("req rose too soon after ack");
	property p_db_held;
		o_req && $past(o_req) && o_io |-> $stable(o_db);
	endproperty
	a_db_held: assert property (p_db_held)
		else $error("sent byte changed under req");
	property p_odd_par;
		o_db_oe |-> ^{o_db, o_dbp};
	endproperty
	a_odd_par: assert property (p_odd_par)
		else $error("driven byte parity not odd");
	property p_oe_in;
		o_db_oe |-> o_io;
	endproperty
	a_oe_in: assert property (p_oe_in)
		else $error("data driven in an out phase");
	property p_rst_free;
		i_rst |-> ##[1:4] !o_bsy;
	endproperty
	a_rst_free: assert property (p_rst_free)
		else $error("bus reset did not release busy");
	property p_pf_free;
		i_power_fail [*2] |=> !o_bsy;
	endproperty
	a_pf_free: assert property (p_pf_free)
		else $error("power fail did not release busy");
	property p_clr_pulse;
		o_lun_cleared |=> !o_lun_cleared;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse)
		else $error("unit clear longer than one cycle");
	property p_rst_clr;
		$rose(i_rst) |-> ##[1:6] o_lun_cleared;
	endproperty
	a_rst_clr: assert property (p_rst_clr)
		else $error("bus reset did not clear the unit");
	property p_stat_top;
		o_req && o_io && o_cd && !o_msg |-> o_db[7:5] == 3'h0;
	endproperty
	a_stat_top: assert property (p_stat_top)
		else $error("status byte top bits not zero");
	property p_wait_one;
		!o_waitrequest |=> o_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low over one cycle");
endmodule // scsi_target_info_chk

bind scsi_target_info scsi_target_info_chk u_chk (.i_clk(i_clk),
	.i_resetn(i_resetn), .i_rst(i_rst), .i_ack(i_ack),
	.i_power_fail(i_power_fail), .o_db(o_db), .o_dbp(o_dbp),
	.o_db_oe(o_db_oe), .o_req(o_req), .o_bsy(o_bsy), .o_cd(o_cd),
	.o_io(o_io), .o_msg(o_msg), .o_waitrequest(o_waitrequest),
	.o_lun_cleared(o_lun_cleared));

/* scsi_initiator_model.sv */
/* initiator on the far side: answers req with ack, logs bytes sent
   by the target, feeds queued bytes in out phases.
   assumes true-high phase lines from the target. */
`timescale 1ns/10ps
module scsi_initiator_model
	import scsi_info_pkg::*;
(
	// target side
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic i_io,
	input wire logic i_cd,
	input wire logic i_msg,
	input wire logic [7:0] i_db,
	// initiator side
	output logic o_ack,
	output logic o_atn,
	output logic [7:0] o_db,
	output logic o_dbp
);
	logic [8:0] tx_q[$];
	logic [10:0] rx_q[$];
	logic in_err = 1'b0;
	logic [8:0] b;
	initial begin
		o_ack = 1'b0;
		o_atn = 1'b0;
		o_db = 8'h5A;
		o_dbp = 1'b0;
	end
	// random stalls stand for a slow host
	always @(posedge i_clk) begin
		if (i_req && !o_ack && $urandom_range(3) != 0) begin
			o_ack <= 1'b1;
			if (i_io) begin
				rx_q.push_back({i_msg, i_cd, i_io, i_db});
				// a queued message asks for message out
				if (i_msg && tx_q.size() != 0)
					o_atn <= 1'b1;
				if (in_err && !i_cd) begin
					o_atn <= 1'b1;
					tx_q.push_back({1'b0, MSG_INIT_ERROR});
					in_err <= 1'b0;
				end
			end else begin
				b = tx_q.size() != 0 ? tx_q.pop_front() : {1'b0, MSG_NOP};
				o_db <= b[7:0];
				o_dbp <= ~^b[7:0] ^ b[8];
				if (i_msg)
					o_atn <= 1'b0;
			end
		end else if (!i_req && o_ack) begin
			o_ack <= 1'b0;
			// a released bus does not keep the last byte
			o_db <= ~o_db;
		end
	end
endmodule // scsi_initiator_model

/* test_scsi_target_info.sv */
/* self-checking bench of scsi_target_info with an initiator model.
   assumes standard phase lines and that ctrl bit 1 ends data. */
`timescale 1ns/10ps
module test_scsi_target_info
	import scsi_info_pkg::*;
();
	logic clk, resetn, rd, wr, rst, pf, conn, o_wait, o_oe, o_clr;
	logic o_req, o_bsy, o_cd, o_io, o_msg, o_dbp, ack, atn, dbp;
	logic [7:0] addr, o_db, db, mo;
	logic [31:0] wdata, rdata, q;
	logic [10:0] exp[$];
	int error_cnt = 0, compares = 0, clr_cnt = 0, k, j, hit, cc;
	`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
		error_cnt++; $display("CHECK FAILED %s expected %h seen %h", \
		n, e, s); end end
	scsi_target_info uut (.i_clk(clk), .i_resetn(resetn),
		.i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
		.o_readdata(rdata), .o_waitrequest(o_wait), .i_rst(rst),
		.i_ack(ack), .i_atn(atn), .i_db(db), .i_dbp(dbp), .o_db(o_db),
		.o_dbp(o_dbp), .o_db_oe(o_oe), .o_req(o_req), .o_bsy(o_bsy),
		.o_cd(o_cd), .o_io(o_io), .o_msg(o_msg), .i_power_fail(pf),
		.i_connected(conn), .o_lun_cleared(o_clr));
	scsi_initiator_model ini (.i_clk(clk), .i_req(o_req), .i_io(o_io),
		.i_cd(o_cd), .i_msg(o_msg), .i_db(o_db), .o_ack(ack),
		.o_atn(atn), .o_db(db), .o_dbp(dbp));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) if (o_clr === 1'b1) clr_cnt <= clr_cnt + 1;
	task automatic av(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int t;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		t = 0;
		do begin @(posedge clk); t++; end
		while (o_wait !== 1'b0 && t < 5000);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		`CHK("bus answer", 1'b1, t < 5000)
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
		for (int t = 0; t < 400; t++) begin
			av(1'b0, a, 0, q);
			if ((q & m) === v) break;
		end
	endtask
	task automatic run(input logic [31:0] c, input int n,
		input logic [7:0] st, input logic bad);
		logic [7:0] b, outq[$];
		exp = {};
		ini.rx_q = {};
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			outq.push_back(b);
			if (c[3:2] == JOB_OUT) ini.tx_q.push_back({bad && i == n - 1, b});
		end
		av(1'b1, OFS_CTRL, c | 32'h1, q);
		for (int i = 0; i < n; i++) begin
			b = outq.pop_front();
			if (c[3:2] == JOB_IN) begin
				av(1'b1, OFS_DATA, {24'h0, b}, q);
				exp.push_back({3'b001, b});
			end else begin
				av(1'b0, OFS_DATA, 0, q);
				`CHK("data out", b, q[7:0])
			end
		end
		for (int t = 0; t < 3000 && ini.rx_q.size() < n; t++) @(posedge clk);
		if (n > 0) av(1'b1, OFS_CTRL, c | 32'h3, q);
		if (c[9]) begin
			exp.push_back({3'b111, MSG_SAVE_PTR});
			exp.push_back({3'b111, MSG_DISCONNECT});
		end else begin
			exp.push_back({3'b011, st});
			exp.push_back({3'b111, c[7] ? (c[8] ? MSG_LINKED_FLAG :
				MSG_LINKED) : MSG_CMD_COMPLETE});
		end
		poll(OFS_STATUS, 32'h0100, 32'h0100);
		`CHK("log size", exp.size(), ini.rx_q.size())
		for (int i = 0; i < exp.size() && i < ini.rx_q.size(); i++)
			`CHK("sent byte", exp[i], ini.rx_q[i])
		`CHK("busy", 1'b0, o_bsy)
		av(1'b0, OFS_STATUS, 0, q);
		if (bad) `CHK("parity flag", 1'b1, q[4])
		av(1'b1, OFS_CTRL, 0, q);
		$display("test ctrl %h done", c);
	endtask
	task test_done();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#(4 * 90000);
		error_cnt++;
		test_done();
	end
	initial begin
		{resetn, rd, wr, rst, pf, conn, addr, wdata} = '0;
		void'($urandom(4));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		conn <= 1'b1;
		av(1'b0, OFS_CTRL, 0, q);
		`CHK("ctrl reset", CTRL_RESET_VAL, q)
		av(1'b1, 8'h40, 32'hFFFF_FFFF, q);
		av(1'b0, 8'h40, 0, q);
		`CHK("unmapped", 32'h0, q)
		run(32'h0, 0, {3'h0, ST_GOOD, 1'b0}, 1'b0);
		run(32'h10, 0, {3'h0, ST_GOOD, 1'b1}, 1'b0);
		run(32'h20, 0, {3'h0, ST_BUSY, 1'b0}, 1'b0);
		run(32'h40, 0, {3'h0, ST_RES_CONFLICT, 1'b0}, 1'b0);
		run(32'h80, 0, {3'h0, ST_INTERMEDIATE, 1'b0}, 1'b0);
		run(32'h180, 0, {3'h0, ST_INTERMEDIATE, 1'b0}, 1'b0);
		run(32'h4, 4, {3'h0, ST_GOOD, 1'b0}, 1'b0);
		run(32'h8, 3, {3'h0, ST_GOOD, 1'b0}, 1'b0);
		run(32'h8, 3, {3'h0, ST_CHECK, 1'b0}, 1'b1);
		run(32'h204, 2, 8'h0, 1'b0);
		ini.in_err = 1'b1;
		av(1'b1, OFS_CTRL, 32'h5, q);
		av(1'b1, OFS_DATA, 32'h3C, q);
		poll(OFS_INFO, 32'hFF00, 32'h0500);
		`CHK("error msg", MSG_INIT_ERROR, q[15:8])
		poll(OFS_STATUS, 32'h0100, 32'h0100);
		av(1'b1, OFS_CTRL, 0, q);
		$display("test data in error done");
		for (k = 0; k < 2; k++) begin
			j = clr_cnt;
			av(1'b1, OFS_CTRL, 32'h5, q);
			for (int t = 0; t < 300 && o_bsy !== 1'b1; t++) @(posedge clk);
			@(posedge clk);
			rst <= k == 0;
			pf <= k == 1;
			repeat (6) @(posedge clk);
			`CHK("busy after fault", 1'b0, o_bsy)
			if (k == 0) `CHK("unit cleared", 1'b1, clr_cnt > j)
			rst <= 1'b0;
			pf <= 1'b0;
			av(1'b1, OFS_CTRL, 0, q);
			$display("test fault %0d done", k);
		end
		for (k = 0; k < 5; k++) begin
			j = clr_cnt;
			ini.rx_q = {};
			mo = k == 0 ? MSG_ABORT : k == 1 ? MSG_DEV_RESET : k == 2 ? 8'h03
				: k == 3 ? 8'hC5 : MSG_PARITY_ERR;
			ini.tx_q = {{1'b0, mo}};
			ini.o_atn <= k < 4;
			av(1'b1, OFS_CTRL, 32'h1, q);
			hit = 0;
			cc = 0;
			for (int t = 0; t < 3000 && hit == 0; t++) begin
				@(posedge clk);
				cc = 0;
				foreach (ini.rx_q[i]) begin
					if (k == 2 && ini.rx_q[i][7:0] == MSG_REJECT) hit = 1;
					if (ini.rx_q[i] == {3'b111, MSG_CMD_COMPLETE}) cc++;
				end
				if (k < 2 && clr_cnt > j) hit = 1;
				if (k > 2 && cc == k - 2) hit = 1;
			end
			`CHK("message out answer", 1, hit)
			if (k == 4) `CHK("resent", 2, cc)
			poll(OFS_STATUS, 32'h0100, 32'h0100);
			if (k == 3) begin
				av(1'b0, OFS_INFO, 0, q);
				`CHK("identify", 8'hC5, q[7:0])
			end
			av(1'b1, OFS_CTRL, 0, q);
			$display("test message %0d done", k);
		end
		test_done();
	end
endmodule // test_scsi_target_info
